// *** verilog/eifc_top.v ***
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "eifc_consts.vh"
// External interrupt front end with AHB-Lite register slave.
// Channels 1 to 3 carry the full filter and detection path;
// channels 0, 4 and 5 keep only their enable bit here.
module eifc_top #(
   parameter NSAMP = `EIFC_NC_SAMPLES
) (
   input wire MCLK,
   input wire ARST_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output wire HREADYOUT,
   output wire HRESP,
   input wire [2:0] EXT_IRQ_PIN,
   input wire LF_CLK,
   input wire LOW_SPEED_MODE,
   output wire EXT_IRQ,
   output wire [5:0] CHAN_ENABLE
);
   localparam NCH = 3;

   // Reset release
   reg rst_meta_q;
   reg rst_n_q;

   // Bus state
   reg [15:0] widx_q;
   reg hi_ok_q;
   reg wr_q;
   reg rd_wait_q;

   // Registers
   reg [5:0] chen_q;
   reg [4*NCH-1:0] ctl_q;
   reg [NCH-1:0] lvl_q;
   reg [NCH-1:0] stat_q;
   reg [NCH-1:0] stat_d;
   reg [NCH-1:0] mask_q;

   // Sampling clocks
   reg [3:0] pre_q;
   reg lf_prev_q;
   reg [1:0] lf_cnt_q;
   reg lf_tick_q;

   wire [NCH-1:0] pin_s;
   wire lf_s;
   wire slow_s;
   wire [NCH-1:0] filt;
   wire [NCH-1:0] req;
   wire [NCH-1:0] tick;
   wire addr_phase;
   wire [31:0] wdata;

   // Index match on the word address
   function hit;
      input [15:0] a;
      input hi;
      input [15:0] idx;
      begin
         hit = hi && (a == idx);
      end
   endfunction

   // Gear prescaler tap for a sampling interval code
   function gear_tap;
      input [1:0] nc;
      input [3:0] pre;
      begin
         case (nc)
            `EIFC_NC_DIV1: gear_tap = 1'b1;
            `EIFC_NC_DIV4: gear_tap = (pre[1:0] == 2'h3);
            `EIFC_NC_DIV8: gear_tap = (pre[2:0] == 3'h7);
            default: gear_tap = (pre == 4'hF);
         endcase
      end
   endfunction

   // Reset is asserted at once and released two edges later
   always @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Pins, slow clock and mode strap come from other domains
   eifc_sync #(.W(NCH)) u_pin_sync (
      .clk(MCLK),
      .rst_n(rst_n_q),
      .din(EXT_IRQ_PIN),
      .dout(pin_s)
   );

   eifc_sync #(.W(2)) u_lf_sync (
      .clk(MCLK),
      .rst_n(rst_n_q),
      .din({LOW_SPEED_MODE, LF_CLK}),
      .dout({slow_s, lf_s})
   );

   // Gear clock prescaler; runs free so every tap stays periodic
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pre_q <= 4'h0;
      end else begin
         pre_q <= pre_q + 4'h1;
      end
   end

   // Quarter of the low-frequency clock, from its rising edges
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         lf_prev_q <= 1'b0;
         lf_cnt_q <= 2'h0;
         lf_tick_q <= 1'b0;
      end else begin
         lf_prev_q <= lf_s;
         lf_tick_q <= 1'b0;
         if (lf_s && !lf_prev_q) begin
            lf_cnt_q <= lf_cnt_q + 2'h1;
            lf_tick_q <= (lf_cnt_q == `EIFC_LF_DIV - 1);
         end
      end
   end

   // One filter per channel; the tick source follows the mode
   genvar k;
   generate
      for (k = 0; k < NCH; k = k + 1) begin : g_ch
         assign tick[k] = slow_s ? lf_tick_q
            : gear_tap(ctl_q[4*k+`EIFC_CTL_NC_HI -: 2], pre_q);
         eifc_nc #(.NSAMP(NSAMP)) u_nc (
            .clk(MCLK),
            .rst_n(rst_n_q),
            .en(chen_q[k+1]),
            .pin_s(pin_s[k]),
            .tick(tick[k]),
            .edge_sel(ctl_q[4*k+`EIFC_CTL_ES_HI -: 2]),
            .filt_q(filt[k]),
            .req_q(req[k])
         );
      end
   endgenerate

   // AHB-Lite address phase
   assign addr_phase = HSEL && HTRANS[1] && HREADY;
   assign wdata = HWDATA;

   // Capture the word index; reads add one wait state so that the
   // data comes from a flop and sees any write just before it
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         widx_q <= 16'h0000;
         hi_ok_q <= 1'b0;
         wr_q <= 1'b0;
         rd_wait_q <= 1'b0;
      end else begin
         wr_q <= addr_phase && HWRITE;
         rd_wait_q <= addr_phase && !HWRITE;
         if (addr_phase) begin
            widx_q <= HADDR[17:2];
            hi_ok_q <= (HADDR[31:18] == 14'h0000) && (HADDR[1:0] == 2'h0);
         end
      end
   end

   assign HREADYOUT = ~rd_wait_q;
   assign HRESP = 1'b0;

   // Channel enable register; bits 7 and 6 are not stored
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         chen_q <= `EIFC_RST_CHEN;
      end else if (wr_q && hit(widx_q, hi_ok_q, `EIFC_IDX_CHEN)) begin
         chen_q <= wdata[5:0];
      end
   end

   assign CHAN_ENABLE = chen_q;

   // Control registers accept data only while the channel runs; a
   // disabled channel drops its settings, so software enables first
   generate
      for (k = 0; k < NCH; k = k + 1) begin : g_ctl
         // Index of this channel's control word, kept at the 16-bit word index width
         localparam [15:0] CIDX = `EIFC_IDX_CTL1 + k;
         always @(posedge MCLK or negedge rst_n_q) begin
            if (!rst_n_q) begin
               ctl_q[4*k+3 -: 4] <= `EIFC_RST_CTL;
            end else if (!chen_q[k+1]) begin
               ctl_q[4*k+3 -: 4] <= `EIFC_RST_CTL;
            end else if (wr_q && hit(widx_q, hi_ok_q, CIDX)) begin
               ctl_q[4*k+3 -: 4] <= wdata[3:0];
            end
         end

         // Level seen by the filter when its request fired
         always @(posedge MCLK or negedge rst_n_q) begin
            if (!rst_n_q) begin
               lvl_q[k] <= 1'b0;
            end else if (!chen_q[k+1]) begin
               lvl_q[k] <= 1'b0;
            end else if (req[k]) begin
               lvl_q[k] <= filt[k];
            end
         end
      end
   endgenerate

   // Interrupt latch: a request in the clearing cycle wins.
   // Enable, mode or control changes may fire requests that land
   // here too; software keeps the mask off around such changes.
   always @* begin
      stat_d = stat_q;
      if (wr_q && hit(widx_q, hi_ok_q, `EIFC_IDX_STAT)) begin
         stat_d = stat_q & ~wdata[NCH-1:0];
      end
      stat_d = stat_d | req;
   end

   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_q <= `EIFC_RST_STAT;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Mask register gates latched requests onto the output
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         mask_q <= `EIFC_RST_MASK;
      end else if (wr_q && hit(widx_q, hi_ok_q, `EIFC_IDX_MASK)) begin
         mask_q <= wdata[NCH-1:0];
      end
   end

   assign EXT_IRQ = |(stat_q & mask_q);

   // Read data registered in the wait cycle; unmapped reads give zero
   always @(posedge MCLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         HRDATA <= 32'h00000000;
      end else if (rd_wait_q) begin
         if (hit(widx_q, hi_ok_q, `EIFC_IDX_CHEN)) begin
            HRDATA <= {26'h0000000, chen_q};
         end else if (hit(widx_q, hi_ok_q, `EIFC_IDX_CTL1)) begin
            HRDATA <= {27'h0000000, lvl_q[0], ctl_q[3:0]};
         end else if (hit(widx_q, hi_ok_q, `EIFC_IDX_CTL2)) begin
            HRDATA <= {27'h0000000, lvl_q[1], ctl_q[7:4]};
         end else if (hit(widx_q, hi_ok_q, `EIFC_IDX_CTL3)) begin
            HRDATA <= {27'h0000000, lvl_q[2], ctl_q[11:8]};
         end else if (hit(widx_q, hi_ok_q, `EIFC_IDX_STAT)) begin
            HRDATA <= {29'h00000000, stat_q};
         end else if (hit(widx_q, hi_ok_q, `EIFC_IDX_MASK)) begin
            HRDATA <= {29'h00000000, mask_q};
         end else begin
            HRDATA <= 32'h00000000;
         end
      end
   end

   // Software waits after mode switches before clearing the latch;
   // nothing here enforces it, the latch simply accepts the clear.
endmodule

// *** verilog/eifc_consts.vh ***
// How it works
// - Pin passes noise canceller before detection
// - Enable bits 0..5 gate each channel; here only bits 1..3 gate channels 1 to 3
// - Control writes ignored while channel disabled
// - Edge field: rise, fall, both, reserved
// - Fast modes: sample gear, /4, /8, /16
// - Slow modes: sample at quarter low clock
// - Level bit holds filtered level at request
// - Control bits 7..5 read zero
// - Enable bits 7..6 read zero
// - Enable change may latch spurious request
// - Mode change may latch spurious request
// - Control write may latch spurious request
// - Request sets latch until cleared
`ifndef EIFC_CONSTS_VH
`define EIFC_CONSTS_VH

// Register indices; byte address is four times the index
`define EIFC_IDX_CHEN 16'h0F77
`define EIFC_IDX_CTL1 16'h0FD8
`define EIFC_IDX_CTL2 16'h0FD9
`define EIFC_IDX_CTL3 16'h0FDA
`define EIFC_IDX_STAT 16'h0FDC
`define EIFC_IDX_MASK 16'h0FDD

// Reset values
`define EIFC_RST_CHEN 6'h00
`define EIFC_RST_CTL 4'h0
`define EIFC_RST_STAT 3'h0
`define EIFC_RST_MASK 3'h0

// Control register fields
`define EIFC_CTL_NC_LO 0
`define EIFC_CTL_NC_HI 1
`define EIFC_CTL_ES_LO 2
`define EIFC_CTL_ES_HI 3
`define EIFC_CTL_LVL 4

// Edge select codes
`define EIFC_ES_RISE 2'h0
`define EIFC_ES_FALL 2'h1
`define EIFC_ES_BOTH 2'h2

// Sampling interval codes
`define EIFC_NC_DIV1 2'h0
`define EIFC_NC_DIV4 2'h1
`define EIFC_NC_DIV8 2'h2
`define EIFC_NC_DIV16 2'h3

// Timing counts
`define EIFC_LF_DIV 4
`define EIFC_NC_SAMPLES 3

`endif

// *** verilog/eifc_sync.v ***
`timescale 1ns/1ps
// Two-stage synchroniser for levels from outside the clock domain
module eifc_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta_q;

   // First stage feeds only the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

// *** verilog/eifc_nc.v ***
`timescale 1ns/1ps
`include "eifc_consts.vh"
// Noise canceller and edge detector for one channel
module eifc_nc #(
   parameter NSAMP = `EIFC_NC_SAMPLES
) (
   input wire clk,
   input wire rst_n,
   input wire en,
   input wire pin_s,
   input wire tick,
   input wire [1:0] edge_sel,
   output reg filt_q,
   output reg req_q
);
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg filt_d;
   reg req_d;

   // Count steady sampling ticks at the new level before flipping
   always @* begin
      cnt_d = cnt_q;
      filt_d = filt_q;
      req_d = 1'b0;
      if (!en) begin
         cnt_d = 4'h0;
         filt_d = 1'b0;
      end else if (tick) begin
         if (pin_s == filt_q) begin
            cnt_d = 4'h0;
         end else if (cnt_q == NSAMP[3:0] - 4'h1) begin
            cnt_d = 4'h0;
            filt_d = pin_s;
            case (edge_sel)
               `EIFC_ES_RISE: req_d = pin_s;
               `EIFC_ES_FALL: req_d = ~pin_s;
               `EIFC_ES_BOTH: req_d = 1'b1;
               default: req_d = 1'b0;
            endcase
         end else begin
            cnt_d = cnt_q + 4'h1;
         end
      end
   end

   // A short pulse never reaches the count, so it is dropped
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         filt_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         filt_q <= filt_d;
         req_q <= req_d;
      end
   end
endmodule

// *** test/eifc_props.sv ***
`timescale 1ns/1ps
// Watches the front end's ports; bus data phases are tracked in helpers
module eifc_props #(
   parameter NSAMP = 3
) (
   input wire MCLK,
   input wire ARST_N,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   input wire [31:0] HRDATA,
   input wire HREADYOUT,
   input wire HRESP,
   input wire [2:0] EXT_IRQ_PIN,
   input wire LF_CLK,
   input wire LOW_SPEED_MODE,
   input wire EXT_IRQ,
   input wire [5:0] CHAN_ENABLE
);
   reg wdp_q;
   reg rdp_q;
   reg [15:0] adr_q;
   reg [2:0] pin_q;
   reg [3:0] stab_q;
   wire tk = HSEL & HTRANS[1] & HREADY;
   wire rdone = rdp_q & HREADYOUT;
   // Data phase flags; stab_q counts quiet pin cycles, saturating
   always @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wdp_q <= 1'b0;
         rdp_q <= 1'b0;
         adr_q <= 16'h0000;
         pin_q <= 3'h0;
         stab_q <= 4'h0;
      end else begin
         wdp_q <= tk & HWRITE;
         rdp_q <= tk ? ~HWRITE : (rdp_q & ~HREADYOUT);
         if (tk)
            adr_q <= HADDR[15:0];
         pin_q <= EXT_IRQ_PIN;
         if (EXT_IRQ_PIN != pin_q)
            stab_q <= 4'h0;
         else if (stab_q != 4'hF)
            stab_q <= stab_q + 4'h1;
      end
   end
   default clocking @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   rd_wait_a: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read data phase not one wait cycle");
   chen_value_a: assert property (wdp_q && adr_q == 16'h3DDC |=>
      CHAN_ENABLE == $past(HWDATA[5:0])) else $error("enable write not taken");
   chen_hold_a: assert property (!$stable(CHAN_ENABLE) |->
      $past(wdp_q) && $past(adr_q) == 16'h3DDC) else $error("enable changed alone");
   chen_rd_a: assert property (rdone && adr_q == 16'h3DDC |->
      HRDATA == {26'h0, CHAN_ENABLE}) else $error("enable readback wrong");
   ctl_rd_a: assert property (rdone && adr_q >= 16'h3F60 && adr_q <= 16'h3F68 |->
      HRDATA[31:5] == 27'h0) else $error("control upper bits set");
   ctl_off_a: assert property (rdone && adr_q == 16'h3F60 && !CHAN_ENABLE[1] |->
      HRDATA == 32'h0) else $error("disabled control not zero");
   irq_hold_a: assert property ($fell(EXT_IRQ) |-> $past(wdp_q))
      else $error("interrupt dropped without a write");
   irq_filter_a: assert property ($rose(EXT_IRQ) |->
      $past(wdp_q) || stab_q >= NSAMP) else $error("interrupt on unsettled pin");
   cover property ($rose(EXT_IRQ));
   cover property ($fell(EXT_IRQ));
   cover property (rdone && adr_q == 16'h3F60 && HRDATA[4]);
endmodule

bind eifc_top eifc_props #(.NSAMP(NSAMP)) u_props (.*);

// *** test/eifc_pin_src.sv ***
`timescale 1ns/1ps
// Far-side source of the pins; levels move just after a clock edge
module eifc_pin_src (
   input wire clk,
   output reg [2:0] pin
);
   initial pin = 3'h0;
   // Hold a level on one channel
   task automatic hold(input integer ch, input bit v);
      pin[ch-1] <= v;
   endtask
   // Pulse that returns to the old level; short ones probe the filter
   task automatic pulse(input integer ch, input integer len);
      pin[ch-1] <= ~pin[ch-1];
      repeat (len) @(posedge clk);
      pin[ch-1] <= ~pin[ch-1];
   endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "eifc_consts.vh"
module tb_top;
   localparam NS = 3;
   localparam [15:0] AEN = `EIFC_IDX_CHEN * 4;
   localparam [15:0] AC1 = `EIFC_IDX_CTL1 * 4;
   localparam [15:0] AST = `EIFC_IDX_STAT * 4;
   localparam [15:0] AMK = `EIFC_IDX_MASK * 4;
   reg mclk, arst_n, hsel, hwrite, lf_clk, lsm;
   reg [31:0] haddr, hwdata, rv, w;
   reg [1:0] htrans;
   reg [2:0] hsize, lv, m, e;
   wire [31:0] hrdata;
   wire hreadyout, hresp, ext_irq;
   wire [5:0] chen;
   wire [2:0] pin;
   integer miscompares, tests_run, cyc, i, ch, es, nc, d;
   eifc_top #(.NSAMP(NS)) dut (.MCLK(mclk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .EXT_IRQ_PIN(pin),
      .LF_CLK(lf_clk), .LOW_SPEED_MODE(lsm), .EXT_IRQ(ext_irq), .CHAN_ENABLE(chen));
   eifc_pin_src src (.clk(mclk), .pin(pin));
   // Clocks; the slow one is offset so its phase is unrelated
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial begin
      lf_clk = 1'b0;
      #1.3;
      forever #20 lf_clk = ~lf_clk;
   end
   task automatic chk(input [31:0] s, input [31:0] x);
      tests_run = tests_run + 1;
      if (s !== x) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   // Ready is sampled at the falling edge so the rising edge never races
   task automatic xf(input [15:0] a, input bit wr, input [31:0] wd);
      reg k;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {16'h0000, a};
      hwrite <= wr;
      do begin
         @(negedge mclk) k = hreadyout;
         @(posedge mclk);
      end while (k !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge mclk) k = hreadyout;
         rv = hrdata;
         @(posedge mclk);
      end while (k !== 1'b1);
   endtask
   task automatic wt(input integer n);
      repeat (n) @(posedge mclk);
   endtask
   function automatic [2:0] fired(input integer s, input integer c, input bit r);
      fired = (s == 2 || s == (r ? 0 : 1)) ? 3'h1 << (c - 1) : 3'h0;
   endfunction
   // Short pulse must vanish, long one must latch, at tick period p
   task automatic pw(input integer n, input integer p);
      xf(AMK, 1, 0);
      xf(AC1, 1, n);
      xf(AST, 1, 7);
      src.pulse(1, p * (NS - 1));
      wt(p * (NS + 2) + 8);
      xf(AST, 0, 0);
      chk(rv, 0);
      src.pulse(1, p * (NS + 1));
      wt(p * (NS + 2) + 8);
      xf(AST, 0, 0);
      chk(rv, 1);
      xf(AST, 1, 7);
   endtask
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         end_of_test;
      end
   end
   initial begin
      {arst_n, hsel, hwrite, lsm, htrans, haddr, hwdata} = 0;
      hsize = 3'h2;
      {miscompares, tests_run, cyc, lv} = 0;
      rv = $urandom(32'h1617);
      wt(2);
      arst_n <= 1'b1;
      wt(3);
      xf(16'h3F6C, 1, 32'hFFFFFFFF);
      xf(16'h3F6C, 0, 0);
      chk(rv, 0);
      xf(AC1, 1, 32'h1F);
      xf(AC1, 0, 0);
      chk(rv, 0);
      xf(AEN, 1, $urandom | 32'h3F);
      xf(AEN, 0, 0);
      chk(rv, 32'h3F);
      chk(chen, 6'h3F);
      chk(hresp, 0);
      $display("test registers done");
      for (i = 0; i < 8; i = i + 1) begin
         es = i % 4;
         ch = 1 + $urandom % 3;
         nc = $urandom % 4;
         d = (nc == 0) ? 1 : (2 << nc);
         m = $urandom;
         xf(AMK, 1, 0);
         xf(AC1 + 4 * (ch - 1), 1, ($urandom & 32'hFFFFFFE0) | (es << 2) | nc);
         xf(AC1 + 4 * (ch - 1), 0, 0);
         chk(rv, (lv[ch-1] << 4) | (es << 2) | nc);
         xf(AST, 1, 7);
         xf(AMK, 1, m);
         src.hold(ch, 1);
         wt(d * (NS + 2) + 8);
         e = fired(es, ch, 1);
         lv = lv | e;
         xf(AST, 0, 0);
         chk(rv, e);
         chk(ext_irq, |(e & m));
         xf(AC1 + 4 * (ch - 1), 0, 0);
         chk(rv[4], lv[ch-1]);
         xf(AST, 1, 7);
         src.hold(ch, 0);
         wt(d * (NS + 2) + 8);
         e = fired(es, ch, 0);
         lv = lv & ~e;
         xf(AST, 0, 0);
         chk(rv, e);
         xf(AST, 1, 7);
      end
      $display("test edge modes done");
      for (i = 0; i < 4; i = i + 1)
         pw(i, (i == 0) ? 1 : (2 << i));
      $display("test sample rates done");
      xf(AMK, 1, 0);
      lsm <= 1'b1;
      wt(12 * 8 + 8);
      xf(AST, 1, 7);
      pw($urandom % 4, 32);
      lsm <= 1'b0;
      wt(12 * 8);
      xf(AST, 1, 7);
      $display("test slow mode done");
      xf(AC1, 1, 32'h8);
      src.hold(1, 1);
      wt(NS + 10);
      xf(AC1, 0, 0);
      chk(rv, 32'h18);
      xf(AEN, 1, 32'h3D);
      xf(AC1, 0, 0);
      chk(rv, 0);
      xf(AEN, 1, 32'h3F);
      wt(NS + 10);
      chk(ext_irq, 0);
      xf(AST, 1, 7);
      xf(AST, 0, 0);
      chk(rv, 0);
      $display("test enable change done");
      end_of_test;
   end
endmodule
